// [logic/half_bridge_pkg.sv]
package half_bridge_pkg;

   localparam int WORD_W     = 16;
   localparam int CHAN_N     = 12;
   localparam int CNT_W      = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
   localparam logic [CNT_W-1:0] CNT_MAX    = 5'h1F;

   // control word field positions
   localparam int CTL_CLEAR_BIT  = 0;
   localparam int CTL_SW_LSB     = 1;
   localparam int CTL_OL_OFF_BIT = 13;
   localparam int CTL_DELAY_BIT  = 14;
   localparam int CTL_RUN_BIT    = 15;

   // status word field positions
   localparam int STS_PREWARN_BIT = 0;
   localparam int STS_SW_LSB      = 1;
   localparam int STS_SHORT_BIT   = 13;
   localparam int STS_STANDBY_BIT = 14;
   localparam int STS_SUPPLY_BIT  = 15;

   // all switches off, open-load check on, short delay, standby
   localparam logic [WORD_W-1:0] CTL_RESET = 16'h0000;

   // timing
   localparam int CLK_PERIOD_NS     = 50;
   localparam int SHORT_DLY_LONG_US = 12000;
   localparam int SHORT_DLY_SHRT_US = 1500;
   localparam int SHORT_LONG_CYC    = SHORT_DLY_LONG_US * 1000 / CLK_PERIOD_NS;
   localparam int SHORT_SHRT_CYC    = SHORT_DLY_SHRT_US * 1000 / CLK_PERIOD_NS;
   localparam int DLY_W             = 18;

   // synchroniser lane layout
   localparam int SYN_CS   = 0;
   localparam int SYN_INH  = 1;
   localparam int SYN_TP   = 2;
   localparam int SYN_OT   = 3;
   localparam int SYN_UV   = 4;
   localparam int SYN_SC   = 5;
   localparam int SYN_OL   = SYN_SC + CHAN_N;
   localparam int SYN_W    = SYN_OL + CHAN_N;
   // lanes reset to their idle level: select high, everything else low
   localparam logic [SYN_W-1:0] SYN_IDLE = SYN_W'(1'b1) << SYN_CS;

endpackage

// [logic/level_sync.sv]
`timescale 1ns/100ps
module level_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   // levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // ----------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------
   // idle-level reset, so no false edge follows release
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule // level_sync

// [logic/half_bridge_serial_control.sv]
`timescale 1ns/100ps
module half_bridge_serial_control
   import half_bridge_pkg::*;
#(
   parameter int SHORT_LONG_CYCLES = half_bridge_pkg::SHORT_LONG_CYC,
   parameter int SHORT_SHRT_CYCLES = half_bridge_pkg::SHORT_SHRT_CYC
) (
   // system clock and reset
   input  wire logic                                clk_sys_i,
   input  wire logic                                rst_b_i,
   // serial link from host
   input  wire logic                                link_clk_i,
   input  wire logic                                cs_b_i,
   input  wire logic                                serial_in_i,
   output logic                                     serial_out_o,
   output logic                                     serial_out_oe_o,
   // analog monitor levels
   input  wire logic                                inhibit_pin_i,
   input  wire logic                                temp_prewarn_i,
   input  wire logic                                overtemp_i,
   input  wire logic                                power_stage_supply_low_i,
   input  wire logic [half_bridge_pkg::CHAN_N-1:0]  short_det_i,
   input  wire logic [half_bridge_pkg::CHAN_N-1:0]  open_load_i,
   // power stage controls
   output logic      [5:0]                          low_side_switch_on_o,
   output logic      [5:0]                          high_side_switch_on_o,
   output logic                                     open_load_check_off_o,
   output logic                                     short_delay_select_o,
   output logic                                     standby_state_o
);

   import half_bridge_pkg::*;

   // ----------------------------------------------------------------
   // link domain: frame marker
   // ----------------------------------------------------------------
   // the link clock stops between frames, so a new frame is spotted
   // by a marker set on the select falling edge itself; it is set
   // opposite to the receiver's last id, so empty frames never alias
   logic frame_id_ff;
   logic rx_id_ff;

   always_ff @(negedge cs_b_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frame_id_ff <= 1'b0;
      end else begin
         frame_id_ff <= ~rx_id_ff;
      end
   end

   // ----------------------------------------------------------------
   // link domain: receive on falling clock
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] rx_word_ff;
   logic [CNT_W-1:0]  rx_cnt_ff;
   logic              rx_new;

   assign rx_new = (rx_id_ff != frame_id_ff);

   always_ff @(negedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_word_ff <= '0;
      end else if (!cs_b_i) begin
         rx_word_ff <= {serial_in_i, rx_word_ff[WORD_W-1:1]};
      end
   end

   // count saturates so a long frame never wraps back to sixteen
   always_ff @(negedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_cnt_ff <= '0;
         rx_id_ff  <= 1'b0;
      end else if (!cs_b_i) begin
         rx_id_ff <= frame_id_ff;
         if (rx_new) begin
            rx_cnt_ff <= 5'h01;
         end else if (rx_cnt_ff != CNT_MAX) begin
            rx_cnt_ff <= rx_cnt_ff + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // link domain: transmit on rising clock
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] tx_idx_ff;
   logic             tx_id_ff;
   logic [WORD_W-1:0] status_hold_ff;
   logic [3:0]       tx_sel;

   // index follows falling edges seen, so either clock idle level works
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_idx_ff <= '0;
         tx_id_ff  <= 1'b0;
      end else if (!cs_b_i) begin
         tx_id_ff  <= frame_id_ff;
         tx_idx_ff <= rx_new ? 5'h00 : rx_cnt_ff;
      end
   end

   always_comb begin
      if (tx_id_ff != frame_id_ff || tx_idx_ff >= FRAME_BITS) begin
         tx_sel = 4'h0;
      end else begin
         tx_sel = tx_idx_ff[3:0];
      end
   end

   assign serial_out_o    = status_hold_ff[tx_sel];
   assign serial_out_oe_o = ~cs_b_i;

   // ----------------------------------------------------------------
   // system domain: input synchronisers
   // ----------------------------------------------------------------
   logic [SYN_W-1:0] syn_in;
   logic [SYN_W-1:0] syn_out;
   logic             cs_s;
   logic             inh_s;
   logic             tp_s;
   logic             ot_s;
   logic             uv_s;
   logic [CHAN_N-1:0] sc_s;
   logic [CHAN_N-1:0] ol_s;

   assign syn_in = {open_load_i, short_det_i, power_stage_supply_low_i,
                    overtemp_i, temp_prewarn_i, inhibit_pin_i, cs_b_i};

   level_sync #(
      .WIDTH     (SYN_W),
      .RESET_VAL (SYN_IDLE)
   ) u_sync (
      .clk_i       (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .async_i     (syn_in),
      .sync_o      (syn_out)
   );

   assign cs_s  = syn_out[SYN_CS];
   assign inh_s = syn_out[SYN_INH];
   assign tp_s  = syn_out[SYN_TP];
   assign ot_s  = syn_out[SYN_OT];
   assign uv_s  = syn_out[SYN_UV];
   assign sc_s  = syn_out[SYN_SC +: CHAN_N];
   assign ol_s  = syn_out[SYN_OL +: CHAN_N];

   // ----------------------------------------------------------------
   // system domain: frame end and word apply
   // ----------------------------------------------------------------
   // rx word and count are quiet once select is high, so they are
   // read only after the synchronised select has risen
   logic              cs_prev_ff;
   logic              cs_rise;
   logic              apply;
   logic              clear;
   logic [WORD_W-1:0] control_ff;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cs_prev_ff <= 1'b1;
      end else begin
         cs_prev_ff <= cs_s;
      end
   end

   assign cs_rise = cs_s & ~cs_prev_ff;
   // a frame with no clock edges leaves the old count: the id check drops it
   assign apply   = cs_rise & (rx_cnt_ff == FRAME_BITS) & (rx_id_ff == frame_id_ff);
   assign clear   = apply & rx_word_ff[CTL_CLEAR_BIT];

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         control_ff <= CTL_RESET;
      end else if (apply) begin
         control_ff <= rx_word_ff;
      end
   end

   // ----------------------------------------------------------------
   // system domain: modes
   // ----------------------------------------------------------------
   logic standby;
   logic ol_check_on;
   logic long_delay;

   assign standby     = ~control_ff[CTL_RUN_BIT] | ~inh_s;
   assign ol_check_on = ~control_ff[CTL_OL_OFF_BIT];
   assign long_delay  = control_ff[CTL_DELAY_BIT];

   // ----------------------------------------------------------------
   // system domain: sticky flags
   // ----------------------------------------------------------------
   // a fault in the clearing cycle survives the clear
   logic ot_flag_ff;
   logic short_flag_ff;
   logic supply_flag_ff;
   logic short_trip;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ot_flag_ff     <= 1'b0;
         short_flag_ff  <= 1'b0;
         supply_flag_ff <= 1'b0;
      end else begin
         ot_flag_ff     <= ot_s | (ot_flag_ff & ~clear);
         short_flag_ff  <= short_trip | (short_flag_ff & ~clear);
         supply_flag_ff <= uv_s | (supply_flag_ff & ~clear);
      end
   end

   // ----------------------------------------------------------------
   // system domain: short-circuit shutdown
   // ----------------------------------------------------------------
   // one shared timer: all shorted switches go off together
   logic [DLY_W-1:0]  dly_cnt_ff;
   logic [DLY_W-1:0]  dly_limit;
   logic [CHAN_N-1:0] killed_ff;
   logic [CHAN_N-1:0] sw_cmd;
   logic [CHAN_N-1:0] sw_on;
   logic [CHAN_N-1:0] shorted;

   assign dly_limit = long_delay ? DLY_W'(SHORT_LONG_CYCLES)
                                 : DLY_W'(SHORT_SHRT_CYCLES);
   assign sw_cmd    = control_ff[CTL_SW_LSB +: CHAN_N];
   assign sw_on     = (standby | ot_flag_ff) ? '0 : (sw_cmd & ~killed_ff);
   assign shorted   = sc_s & sw_on;
   assign short_trip = (|shorted) && (dly_cnt_ff >= dly_limit - DLY_W'(1));

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dly_cnt_ff <= '0;
      end else if (!(|shorted) || short_trip) begin
         dly_cnt_ff <= '0;
      end else begin
         dly_cnt_ff <= dly_cnt_ff + DLY_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         killed_ff <= '0;
      end else begin
         killed_ff <= (short_trip ? shorted : '0) | (clear ? '0 : killed_ff);
      end
   end

   // ----------------------------------------------------------------
   // system domain: power stage outputs
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_half
         assign low_side_switch_on_o[g]  = sw_on[2*g];
         assign high_side_switch_on_o[g] = sw_on[2*g+1];
      end
   endgenerate

   assign open_load_check_off_o = ~ol_check_on;
   assign short_delay_select_o  = long_delay;
   assign standby_state_o       = standby;

   // ----------------------------------------------------------------
   // system domain: status word
   // ----------------------------------------------------------------
   logic [CHAN_N-1:0] chan_sts;
   logic [WORD_W-1:0] status_now;

   // open load is only meaningful with the switch off
   assign chan_sts = ol_check_on ? (ol_s & ~sw_on) : sw_on;

   always_comb begin
      status_now                               = '0;
      status_now[STS_PREWARN_BIT]              = tp_s;
      status_now[STS_SW_LSB +: CHAN_N]         = chan_sts;
      status_now[STS_SHORT_BIT]                = short_flag_ff;
      status_now[STS_STANDBY_BIT]              = standby;
      status_now[STS_SUPPLY_BIT]               = supply_flag_ff;
   end

   // frozen while select is low; the link side reads it as static
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_hold_ff <= '0;
      end else if (cs_s) begin
         status_hold_ff <= status_now;
      end
   end

endmodule // half_bridge_serial_control

// [sim/half_bridge_serial_control_assertions.sv]
`timescale 1ns/100ps
module half_bridge_serial_control_assertions
   import half_bridge_pkg::*;
#(
   parameter int SHORT_LONG_CYCLES = 40,
   parameter int SHORT_SHRT_CYCLES = 8
) (
   // clock, reset, link
   input wire logic                               clk_sys_i,
   input wire logic                               rst_b_i,
   input wire logic                               cs_b_i,
   input wire logic                               serial_out_oe_o,
   // monitors and controls
   input wire logic                               inhibit_pin_i,
   input wire logic                               overtemp_i,
   input wire logic [half_bridge_pkg::CHAN_N-1:0] short_det_i,
   input wire logic [5:0]                         low_side_switch_on_o,
   input wire logic [5:0]                         high_side_switch_on_o,
   input wire logic                               open_load_check_off_o,
   input wire logic                               short_delay_select_o,
   input wire logic                               standby_state_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic [11:0] sw;
   int          run_ff;
   always_comb for (int k = 0; k < 6; k++) {sw[2*k+1], sw[2*k]} = {high_side_switch_on_o[k], low_side_switch_on_o[k]};
   // cycles a commanded-on switch has been shorted
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
      if (!rst_b_i)
         run_ff <= 0;
      else
         run_ff <= |(short_det_i & sw) ? run_ff + 1 : 0;
   sequence s_frame_end;
      $past(cs_b_i, 2) && !$past(cs_b_i, 6);
   endsequence
   a_release_high: assert property (cs_b_i |-> !serial_out_oe_o) else $error("output driven while deselected");
   a_drive_low: assert property (!cs_b_i |-> serial_out_oe_o) else $error("output not driven in frame");
   a_ctl_after_rise: assert property ($changed({open_load_check_off_o, short_delay_select_o}) |-> s_frame_end)
      else $error("control bit moved outside frame end");
   a_switch_on_late: assert property ((sw & ~$past(sw)) != 12'h000 |-> s_frame_end)
      else $error("switch turned on outside frame end");
   a_standby_pin: assert property ((!inhibit_pin_i)[*3] |-> ##1 standby_state_o) else $error("pin standby lost");
   a_run_needs_pin: assert property (!standby_state_o |-> $past(inhibit_pin_i, 2)) else $error("run without pin");
   a_overtemp_kill: assert property (overtemp_i[*3] |-> ##1 sw == 12'h000) else $error("overtemp kept switch on");
   a_short_kill: assert property (run_ff <= (short_delay_select_o ? SHORT_LONG_CYCLES : SHORT_SHRT_CYCLES) + 6)
      else $error("shorted switch not shut down in time");
endmodule // half_bridge_serial_control_assertions

// [sim/spi_host_model.sv]
`timescale 1ns/100ps
module spi_host_model (
   // link outputs
   output logic       link_clk_o,
   output logic       cs_b_o,
   output logic       sdi_o,
   // return line
   input  wire logic  sdo_i,
   input  wire logic  oe_i,
   input  wire logic  fill_i,
   output logic [7:0] glitch_o
);
   // released line shows a moving pattern, not the last bit
   wire do_line = oe_i ? sdo_i : fill_i;
   initial begin
      link_clk_o = 1'b0;
      cs_b_o = 1'b1;
      sdi_o = 1'b0;
      glitch_o = 8'h00;
   end
   task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rx);
      logic p;
      rx = 32'h0;
      cs_b_o = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         #5 sdi_o = w[i];
         #10 link_clk_o = 1'b1;
         #2 p = do_line;
         #13 rx[i] = do_line;
         if (p !== rx[i]) glitch_o = glitch_o + 8'h01;
         link_clk_o = 1'b0;
      end
      #15 cs_b_o = 1'b1;
      sdi_o = ~sdi_o;
      #250;
   endtask
endmodule // spi_host_model

// [sim/half_bridge_serial_control_tb.sv]
`timescale 1ns/100ps
module half_bridge_serial_control_tb;
   import half_bridge_pkg::*;
   localparam int LONG_CYC = 40;
   localparam int SHRT_CYC = 8;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b1;
   logic        standby_state = 1'b1, tp = 1'b0, ot = 1'b0, uv = 1'b0, short_shutdown_flag = 1'b0, supply_fail_flag = 1'b0;
   logic [11:0] sc = 12'h000, ol = 12'h000, kill = 12'h000;
   logic        link_clk, cs_b, sdi, sdo, oe, olo, sdl, sby;
   logic [5:0]  ls, hs;
   logic [7:0]  glitch;
   logic [15:0] cur, c, outw;
   logic [31:0] rx;
   int          error_cnt = 0, compares = 0, seed = 32'h0A1C;
   always #25 clk_sys_i = ~clk_sys_i;
   half_bridge_serial_control #(.SHORT_LONG_CYCLES(LONG_CYC), .SHORT_SHRT_CYCLES(SHRT_CYC)) u_dut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk), .cs_b_i(cs_b), .serial_in_i(sdi),
      .serial_out_o(sdo), .serial_out_oe_o(oe), .inhibit_pin_i(standby_state), .temp_prewarn_i(tp), .overtemp_i(ot),
      .power_stage_supply_low_i(uv), .short_det_i(sc), .open_load_i(ol), .low_side_switch_on_o(ls),
      .high_side_switch_on_o(hs), .open_load_check_off_o(olo), .short_delay_select_o(sdl), .standby_state_o(sby));
   spi_host_model u_host (.link_clk_o(link_clk), .cs_b_o(cs_b), .sdi_o(sdi), .sdo_i(sdo), .oe_i(oe),
      .fill_i(clk_sys_i), .glitch_o(glitch));
   always_comb begin
      outw = {~sby, sdl, olo, 13'h0000};
      for (int k = 0; k < 6; k++) {outw[2*k+2], outw[2*k+1]} = {hs[k], ls[k]};
   end
   function automatic logic [15:0] exp_out(logic [15:0] w);
      return {w[15] & standby_state, w[14], w[13], w[12:1] & ~kill, 1'b0};
   endfunction
   function automatic logic [15:0] exp_sts(logic [15:0] w);
      logic [11:0] s;
      s = w[12:1] & ~kill;
      return {supply_fail_flag, ~(w[15] & standby_state), short_shutdown_flag, w[13] ? s : ol & ~s, tp};
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(logic [31:0] w, int n);
      logic [15:0] e;
      e = exp_sts(cur);
      @(negedge clk_sys_i);
      u_host.frame(w, n, rx);
      if (n >= 16) chk(rx[15:0], e);
      if (n == 16) cur = w[15:0];
      // faults are gone before any clear word is sent
      if (n == 16 && w[0]) {short_shutdown_flag, supply_fail_flag, kill} = 14'h0000;
      repeat (5) @(negedge clk_sys_i);
      chk(outw, exp_out(cur));
   endtask
   task automatic results;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      results();
   end
   initial begin
      cur = 16'h0000;
      // a real falling edge, so flops clocked only by link edges reset too
      #1 rst_b_i = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      chk(outw, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         c = i == 0 ? 16'hFFFE : i == 1 ? 16'h8000 : 16'($random(seed));
         c[0] = 1'b0;
         // standby words carry no switch commands
         if (!c[15]) c[12:1] = 12'h000;
         tp = 1'($random(seed));
         ol = 12'($random(seed));
         xfer(c, 16);
      end
      uv = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      uv = 1'b0;
      supply_fail_flag = 1'b1;
      xfer({16'h0000, ~cur | 16'h0001}, 15);
      xfer({16'h0001, ~cur | 16'h0001}, 17);
      xfer(cur | 16'h0001, 16);
      for (int d = 0; d < 2; d++) begin
         xfer(d ? 32'hC003 : 32'h8003, 16);
         sc[0] = 1'b1;
         repeat (d ? 30 : 4) @(negedge clk_sys_i);
         chk(outw, exp_out(cur));
         repeat (d ? 20 : 12) @(negedge clk_sys_i);
         kill[0] = 1'b1;
         short_shutdown_flag = 1'b1;
         chk(outw, exp_out(cur));
         sc[0] = 1'b0;
      end
      // empty frame must not re-fire the last clear word
      xfer(32'h0000, 0);
      ot = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      ot = 1'b0;
      kill = 12'hFFF;
      chk(outw, exp_out(cur));
      xfer(cur | 16'h0001, 16);
      xfer(32'hA000, 16);
      standby_state = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      chk(outw, exp_out(cur));
      xfer(32'hA000, 16);
      standby_state = 1'b1;
      chk({8'h00, glitch}, 16'h0000);
      results();
   end
endmodule // half_bridge_serial_control_tb
bind half_bridge_serial_control half_bridge_serial_control_assertions #(
   .SHORT_LONG_CYCLES(SHORT_LONG_CYCLES), .SHORT_SHRT_CYCLES(SHORT_SHRT_CYCLES)) u_chk (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .serial_out_oe_o(serial_out_oe_o),
   .inhibit_pin_i(inhibit_pin_i), .overtemp_i(overtemp_i), .short_det_i(short_det_i),
   .low_side_switch_on_o(low_side_switch_on_o), .high_side_switch_on_o(high_side_switch_on_o),
   .open_load_check_off_o(open_load_check_off_o), .short_delay_select_o(short_delay_select_o),
   .standby_state_o(standby_state_o));
